// ---- tb/ltc_listen_regs_sva.sv ----
// checker: port-level assertions for the listen/tx config register group
module ltc_listen_regs_sva
  import ltc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic [7:0] O_RDATA,
  input wire logic O_RX_ON,
  input wire logic O_FIFO_CLEAR,
  input wire logic O_AMP_ZERO_EN,
  input wire logic O_AMP_ONE_EN,
  input wire logic O_AMP_TWO_EN,
  input wire logic [4:0] O_POWER_CODE,
  input wire logic [3:0] O_RAMP_TIME_CODE,
  input wire logic O_OCP_EN,
  input wire logic [3:0] O_OCP_LIMIT_CODE
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wd_q;
  logic [7:0] lvl;
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  always_ff @(posedge I_SYS_CLK) begin
    wd_q <= I_WDATA;
  end
  assign lvl = {O_AMP_ZERO_EN, O_AMP_ONE_EN, O_AMP_TWO_EN, O_POWER_CODE};
  a_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
    else $error("read data not zero outside read");
  a_rev_read: assert property (I_RD && I_ADDR == ADDR_REVISION |=> O_RDATA == REVISION_CODE)
    else $error("revision read wrong");
  a_unmap_read: assert property (I_RD && I_ADDR > ADDR_OVERCURRENT
    && I_ADDR < ADDR_LISTEN_CTRL |=> O_RDATA == 8'h00)
    else $error("unmapped read not zero");
  a_ramp_read: assert property (I_RD && I_ADDR == ADDR_AMP_RAMP
    |=> O_RDATA == {4'h0, O_RAMP_TIME_CODE})
    else $error("ramp read differs from output");
  a_ocp_read: assert property (I_RD && I_ADDR == ADDR_OVERCURRENT
    |=> O_RDATA == {3'h0, O_OCP_EN, O_OCP_LIMIT_CODE})
    else $error("overcurrent read differs from output");
  a_ramp_write: assert property (I_WR && I_ADDR == ADDR_AMP_RAMP
    |=> O_RAMP_TIME_CODE == wd_q[3:0])
    else $error("ramp write not applied");
  a_cal_read: assert property (I_RD && I_ADDR == ADDR_OSC_CAL |=> !O_RDATA[7])
    else $error("calibration trigger bit not read as zero");
  a_level_write: assert property (I_WR && I_ADDR == ADDR_AMP_LEVEL |=> lvl == wd_q)
    else $error("amplifier level write not applied");
  a_level_hold: assert property (!(I_WR && I_ADDR == ADDR_AMP_LEVEL) |=> $stable(lvl))
    else $error("amplifier level changed without write");
  a_ocp_write: assert property (I_WR && I_ADDR == ADDR_OVERCURRENT
    |=> {O_OCP_EN, O_OCP_LIMIT_CODE} == wd_q[4:0])
    else $error("overcurrent write not applied");
  a_fifo_pulse: assert property (O_FIFO_CLEAR |=> !O_FIFO_CLEAR)
    else $error("fifo clear longer than one cycle");
  a_fifo_wake: assert property (O_FIFO_CLEAR |-> ##[0:2] O_RX_ON)
    else $error("fifo clear away from receive wakeup");
endmodule

bind ltc_listen_regs ltc_listen_regs_sva chk_u (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_RX_ON(O_RX_ON),
  .O_FIFO_CLEAR(O_FIFO_CLEAR), .O_AMP_ZERO_EN(O_AMP_ZERO_EN),
  .O_AMP_ONE_EN(O_AMP_ONE_EN), .O_AMP_TWO_EN(O_AMP_TWO_EN), .O_POWER_CODE(O_POWER_CODE),
  .O_RAMP_TIME_CODE(O_RAMP_TIME_CODE), .O_OCP_EN(O_OCP_EN),
  .O_OCP_LIMIT_CODE(O_OCP_LIMIT_CODE));

// ---- tb/ltc_listen_regs_tb_top.sv ----
// testbench: register access and listen sequencing of the config block
module ltc_listen_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import ltc_pkg::*;
  localparam int TK = BASE_TICK_CYC;
  localparam int IDLE_N = 1;
  localparam int RX_N = 2;
  logic clk, rstn, wr_s, rd_s, lvl, sync, pay, tmo, fifo_seen;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] op_mode;
  logic rx_on, fifo_clr, amp0, amp1, amp2, ocp_en;
  logic [4:0] power;
  logic [3:0] ramp, ocp_lim;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;
  int n;
  ltc_listen_regs dut_u (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr_s),
    .I_RD(rd_s), .I_LEVEL_ABOVE_FLOOR(lvl), .I_SYNC_WORD_MATCH(sync),
    .I_PAYLOAD_COMPLETE(pay), .I_RX_TIMEOUT(tmo), .O_RDATA(rdata), .O_OP_MODE(op_mode),
    .O_RX_ON(rx_on), .O_FIFO_CLEAR(fifo_clr), .O_AMP_ZERO_EN(amp0), .O_AMP_ONE_EN(amp1),
    .O_AMP_TWO_EN(amp2), .O_POWER_CODE(power), .O_RAMP_TIME_CODE(ramp),
    .O_OCP_EN(ocp_en), .O_OCP_LIMIT_CODE(ocp_lim));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic give_verdict;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    comparisons++;
    if (got != exp) begin
      failures++;
      $display("mismatch t=%0t count %0d exp %0d", $time, got, exp);
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (fifo_clr === 1'b1) fifo_seen <= 1'b1;
    if (cyc == 70000) begin
      failures++;
      $display("mismatch t=%0t run too long", $time);
      give_verdict();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk);
    wr_s <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1 chk8(rdata, e);
  endtask
  // cycles until the receiver reaches level v, capped at lim
  task automatic wait_rx(input logic v, input int lim, output int k);
    k = 0;
    while (rx_on !== v && k < lim) begin
      @(posedge clk);
      #1 k++;
    end
  endtask
  task automatic cycles(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    rd_chk(ADDR_LISTEN_TIMING, 8'h52);
    rd_chk(ADDR_LISTEN_IDLE, 8'hf5);
    rd_chk(ADDR_LISTEN_RX, 8'h20);
    rd_chk(ADDR_REVISION, REVISION_CODE);
    rd_chk(ADDR_AMP_LEVEL, 8'h9f);
    rd_chk(ADDR_AMP_RAMP, 8'h09);
    rd_chk(ADDR_OVERCURRENT, 8'h1a);
    chk8({amp0, amp1, amp2, power}, 8'h9f);
    chk8({3'h0, ocp_en, ocp_lim}, 8'h1a);
    chk8({4'h0, ramp}, 8'h09);
  endtask
  task automatic t_access;
    wr(ADDR_AMP_RAMP, 8'hff);
    rd_chk(ADDR_AMP_RAMP, 8'h0f);
    wr(ADDR_OVERCURRENT, 8'hef);
    rd_chk(ADDR_OVERCURRENT, 8'h0f);
    chk8({3'h0, ocp_en, ocp_lim}, 8'h0f);
    wr(ADDR_REVISION, 8'h00);
    rd_chk(ADDR_REVISION, REVISION_CODE);
    rd_chk(8'h20, 8'h00);
    wr(ADDR_AMP_LEVEL, 8'h70);
    #1 chk8({amp0, amp1, amp2, power}, 8'h70);
    wr(ADDR_LISTEN_TIMING, 8'hff);
    rd_chk(ADDR_LISTEN_TIMING, 8'hfa);
    wr(ADDR_LISTEN_TIMING, 8'h00);
    rd_chk(ADDR_LISTEN_TIMING, 8'hf0);
    wr(ADDR_LISTEN_IDLE, IDLE_N[7:0]);
    wr(ADDR_LISTEN_RX, RX_N[7:0]);
    rd_chk(ADDR_LISTEN_IDLE, IDLE_N[7:0]);
    rd_chk(ADDR_LISTEN_RX, RX_N[7:0]);
  endtask
  task automatic t_cal;
    wr(ADDR_OSC_CAL, 8'h80);
    rd_chk(ADDR_OSC_CAL, 8'h01);
    cycles(CAL_CYCLES);
    rd_chk(ADDR_OSC_CAL, 8'h41);
  endtask
  task automatic t_phases;
    fifo_seen = 1'b0;
    wr(ADDR_LISTEN_TIMING, 8'h54);
    wr(ADDR_LISTEN_CTRL, 8'h01);
    wait_rx(1'b1, 2 * TK, n);
    wait_rx(1'b0, 4 * TK, n);
    chk_n(n, RX_N * TK);
    wait_rx(1'b1, 4 * TK, n);
    chk_n(n, IDLE_N * TK);
    chk8({7'h0, fifo_seen}, 8'h00);
  endtask
  task automatic t_resume;
    @(posedge clk) lvl <= 1'b1;
    cycles(RX_N * TK + 100);
    chk8({7'h0, rx_on}, 8'h01);
    @(posedge clk) pay <= 1'b1;
    @(posedge clk) pay <= 1'b0;
    lvl <= 1'b0;
    wait_rx(1'b0, 20, n);
    chk8({7'h0, rx_on}, 8'h00);
    fifo_seen = 1'b0;
    wait_rx(1'b1, 2 * TK, n);
    chk_n(n, IDLE_N * TK);
    cycles(3);
    chk8({7'h0, fifo_seen}, 8'h01);
    wr(ADDR_LISTEN_CTRL, 8'h00);
  endtask
  task automatic t_goto;
    wr(ADDR_MODE, 8'h08);
    wr(ADDR_MODE, 8'h1c);
    wr(ADDR_OSC_CAL, 8'h80);
    rd_chk(ADDR_OSC_CAL, 8'h41);
    wr(ADDR_LISTEN_TIMING, 8'h52);
    wr(ADDR_LISTEN_CTRL, 8'h01);
    wait_rx(1'b1, 2 * TK, n);
    @(posedge clk) lvl <= 1'b1;
    @(posedge clk) lvl <= 1'b0;
    cycles(5);
    chk8({5'h0, op_mode}, {5'h0, MODE_RX});
    @(posedge clk) tmo <= 1'b1;
    @(posedge clk) tmo <= 1'b0;
    wait_rx(1'b0, 20, n);
    cycles(2);
    chk8({5'h0, op_mode}, 8'h02);
    cycles((IDLE_N + 1) * TK);
    chk8({7'h0, rx_on}, 8'h00);
    wr(ADDR_LISTEN_CTRL, 8'h00);
    wr(ADDR_MODE, 8'h04);
  endtask
  task automatic t_stay;
    wr(ADDR_LISTEN_TIMING, 8'h58);
    lvl <= 1'b1;
    wr(ADDR_LISTEN_CTRL, 8'h01);
    wait_rx(1'b1, 2 * TK, n);
    wait_rx(1'b0, 4 * TK, n);
    chk_n(n, RX_N * TK);
    @(posedge clk) sync <= 1'b1;
    wait_rx(1'b1, 2 * TK, n);
    cycles(RX_N * TK + 100);
    @(posedge clk) pay <= 1'b1;
    @(posedge clk) pay <= 1'b0;
    cycles(10);
    chk8({7'h0, rx_on}, 8'h01);
    wr(ADDR_LISTEN_CTRL, 8'h00);
    cycles(3);
    chk8({7'h0, rx_on}, 8'h00);
    lvl <= 1'b0;
    sync <= 1'b0;
  endtask
  initial begin
    {rstn, wr_s, rd_s, lvl, sync, pay, tmo, fifo_seen} = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_access();
    t_cal();
    t_phases();
    t_resume();
    t_goto();
    t_stay();
    give_verdict();
  end
endmodule

// ---- verilog/ltc_listen_regs.sv ----
// listen sequencer and transmitter configuration register group
module ltc_listen_regs
  import ltc_pkg::*;
(
  input wire logic I_SYS_CLK,
  input wire logic I_RSTN,
  input wire logic [7:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  input wire logic I_LEVEL_ABOVE_FLOOR,
  input wire logic I_SYNC_WORD_MATCH,
  input wire logic I_PAYLOAD_COMPLETE,
  input wire logic I_RX_TIMEOUT,
  output logic [7:0] O_RDATA,
  output logic [2:0] O_OP_MODE,
  output logic O_RX_ON,
  output logic O_FIFO_CLEAR,
  output logic O_AMP_ZERO_EN,
  output logic O_AMP_ONE_EN,
  output logic O_AMP_TWO_EN,
  output logic [4:0] O_POWER_CODE,
  output logic [3:0] O_RAMP_TIME_CODE,
  output logic O_OCP_EN,
  output logic [3:0] O_OCP_LIMIT_CODE
);
  // ------------------------------------------------------------
  // register storage
  // ------------------------------------------------------------
  logic [1:0] idle_tick_select_reg;
  logic [1:0] receive_tick_select_reg;
  logic wake_acceptance_rule_reg;
  logic [1:0] post_accept_action_reg;
  logic [7:0] idle_phase_count_reg;
  logic [7:0] receive_phase_count_reg;
  logic [2:0] mode_reg;
  logic listen_en_reg;
  logic cal_busy_reg;
  logic [7:0] cal_cnt_reg;
  logic [7:0] rdata_next;
  logic wr_timing;
  logic wr_mode;
  logic accept;
  logic tick64;
  logic [11:0] base_cnt_reg;
  logic [11:0] sub_cnt_reg;
  logic [7:0] phase_cnt_reg;
  logic [11:0] sub_limit;
  logic unit_tick;
  logic phase_done;
  logic phase_restart;
  logic pending_flush_reg;
  logic accepted_reg;
  ltc_lstate_t lstate_reg;

  // ------------------------------------------------------------
  // listen configuration registers
  // ------------------------------------------------------------
  assign wr_timing = I_WR && (I_ADDR == ADDR_LISTEN_TIMING);
  assign wr_mode = I_WR && (I_ADDR == ADDR_MODE);

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      idle_tick_select_reg <= RST_TICK_SEL;
      receive_tick_select_reg <= RST_TICK_SEL;
      wake_acceptance_rule_reg <= 1'b0;
      post_accept_action_reg <= RST_POST_ACTION;
    end else if (wr_timing) begin
      // reserved tick code 00 is refused so the timebase never stalls
      if (I_WDATA[7:6] != 2'b00) begin
        idle_tick_select_reg <= I_WDATA[7:6];
      end
      if (I_WDATA[5:4] != 2'b00) begin
        receive_tick_select_reg <= I_WDATA[5:4];
      end
      wake_acceptance_rule_reg <= I_WDATA[3];
      if (I_WDATA[2:1] != 2'b11) begin
        post_accept_action_reg <= I_WDATA[2:1];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      idle_phase_count_reg <= RST_IDLE_COUNT;
      receive_phase_count_reg <= RST_RX_COUNT;
    end else if (I_WR && I_ADDR == ADDR_LISTEN_IDLE) begin
      idle_phase_count_reg <= I_WDATA;
    end else if (I_WR && I_ADDR == ADDR_LISTEN_RX) begin
      receive_phase_count_reg <= I_WDATA;
    end
  end

  // ------------------------------------------------------------
  // transmitter settings
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_AMP_ZERO_EN <= 1'b1;
      O_AMP_ONE_EN <= 1'b0;
      O_AMP_TWO_EN <= 1'b0;
      O_POWER_CODE <= RST_POWER_CODE;
      O_RAMP_TIME_CODE <= RST_RAMP_CODE;
      O_OCP_EN <= 1'b1;
      O_OCP_LIMIT_CODE <= RST_OCP_CODE;
    end else if (I_WR && I_ADDR == ADDR_AMP_LEVEL) begin
      O_AMP_ZERO_EN <= I_WDATA[7];
      O_AMP_ONE_EN <= I_WDATA[6];
      O_AMP_TWO_EN <= I_WDATA[5];
      // power is written as given; lower half with boost amps is host's duty
      O_POWER_CODE <= I_WDATA[4:0];
    end else if (I_WR && I_ADDR == ADDR_AMP_RAMP) begin
      O_RAMP_TIME_CODE <= I_WDATA[3:0];
    end else if (I_WR && I_ADDR == ADDR_OVERCURRENT) begin
      O_OCP_EN <= I_WDATA[4];
      O_OCP_LIMIT_CODE <= I_WDATA[3:0];
    end
  end

  // ------------------------------------------------------------
  // oscillator calibration
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      cal_busy_reg <= 1'b0;
      cal_cnt_reg <= 8'h00;
    end else if (cal_busy_reg) begin
      cal_cnt_reg <= cal_cnt_reg - 8'h01;
      if (cal_cnt_reg == 8'h00) begin
        cal_busy_reg <= 1'b0;
      end
    end else if (I_WR && I_ADDR == ADDR_OSC_CAL && I_WDATA[7] && mode_reg == MODE_STANDBY) begin
      cal_busy_reg <= 1'b1;
      cal_cnt_reg <= 8'(CAL_CYCLES - 1);
    end
  end

  // ------------------------------------------------------------
  // listen timebase
  // ------------------------------------------------------------
  assign tick64 = (base_cnt_reg == 12'(BASE_TICK_CYC - 1));

  always_comb begin
    case (lstate_reg == LS_IDLE ? idle_tick_select_reg : receive_tick_select_reg)
      TICK_4MS: sub_limit = MUL_4MS - 12'h001;
      TICK_262MS: sub_limit = MUL_262MS;
      default: sub_limit = MUL_64US - 12'h001;
    endcase
  end

  assign unit_tick = tick64 && (sub_cnt_reg >= sub_limit);
  assign phase_done = unit_tick && (phase_cnt_reg <= 8'h01);
  assign accept = I_LEVEL_ABOVE_FLOOR && (!wake_acceptance_rule_reg || I_SYNC_WORD_MATCH);
  // any exit from a phase restarts the timebase, so the next phase gets its full length
  assign phase_restart = phase_done
    || (lstate_reg == LS_RX && accepted_reg && (I_PAYLOAD_COMPLETE || I_RX_TIMEOUT));

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN || lstate_reg == LS_OFF || lstate_reg == LS_HOLD || phase_restart) begin
      base_cnt_reg <= 12'h000;
      sub_cnt_reg <= 12'h000;
    end else if (tick64) begin
      base_cnt_reg <= 12'h000;
      sub_cnt_reg <= unit_tick ? 12'h000 : sub_cnt_reg + 12'h001;
    end else begin
      base_cnt_reg <= base_cnt_reg + 12'h001;
    end
  end

  // ------------------------------------------------------------
  // listen sequencer
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      lstate_reg <= LS_OFF;
      phase_cnt_reg <= 8'h00;
      accepted_reg <= 1'b0;
      pending_flush_reg <= 1'b0;
      O_FIFO_CLEAR <= 1'b0;
    end else begin
      O_FIFO_CLEAR <= 1'b0;
      case (lstate_reg)
        LS_OFF: begin
          accepted_reg <= 1'b0;
          if (listen_en_reg) begin
            lstate_reg <= LS_IDLE;
            phase_cnt_reg <= idle_phase_count_reg;
          end
        end
        LS_IDLE: begin
          if (!listen_en_reg) begin
            lstate_reg <= LS_OFF;
          end else if (phase_done) begin
            lstate_reg <= LS_RX;
            phase_cnt_reg <= receive_phase_count_reg;
            O_FIFO_CLEAR <= pending_flush_reg;
            pending_flush_reg <= 1'b0;
          end else if (unit_tick) begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end
        end
        LS_RX: begin
          if (!listen_en_reg) begin
            lstate_reg <= LS_OFF;
          end else if (accepted_reg) begin
            if (I_PAYLOAD_COMPLETE || I_RX_TIMEOUT) begin
              if (post_accept_action_reg == ACT_RESUME) begin
                lstate_reg <= LS_IDLE;
                phase_cnt_reg <= idle_phase_count_reg;
                pending_flush_reg <= 1'b1;
                accepted_reg <= 1'b0;
              end else begin
                lstate_reg <= LS_HOLD;
              end
            end
          end else if (accept) begin
            accepted_reg <= 1'b1;
            if (post_accept_action_reg == ACT_STAY_RX) begin
              lstate_reg <= LS_HOLD;
            end
          end else if (phase_done) begin
            lstate_reg <= LS_IDLE;
            phase_cnt_reg <= idle_phase_count_reg;
          end else if (unit_tick) begin
            phase_cnt_reg <= phase_cnt_reg - 8'h01;
          end
        end
        default: begin
          if (!listen_en_reg) begin
            lstate_reg <= LS_OFF;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // mode and listen enable
  // ------------------------------------------------------------
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      mode_reg <= MODE_STANDBY;
      listen_en_reg <= 1'b0;
    end else begin
      if (wr_mode && I_WDATA[4:2] <= MODE_MAX) begin
        mode_reg <= I_WDATA[4:2];
      end
      if (I_WR && I_ADDR == ADDR_LISTEN_CTRL) begin
        listen_en_reg <= I_WDATA[0];
      end
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_OP_MODE <= MODE_STANDBY;
      O_RX_ON <= 1'b0;
    end else begin
      case (lstate_reg)
        LS_RX: begin
          O_OP_MODE <= MODE_RX;
          O_RX_ON <= 1'b1;
        end
        LS_IDLE: begin
          O_OP_MODE <= MODE_SLEEP;
          O_RX_ON <= 1'b0;
        end
        LS_HOLD: begin
          // action 00 holds receive; action 01 goes to the programmed mode
          O_OP_MODE <= (post_accept_action_reg == ACT_GOTO_MODE) ? mode_reg : MODE_RX;
          O_RX_ON <= (post_accept_action_reg != ACT_GOTO_MODE) || mode_reg == MODE_RX;
        end
        default: begin
          O_OP_MODE <= mode_reg;
          O_RX_ON <= (mode_reg == MODE_RX);
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  always_comb begin
    rdata_next = 8'h00;
    if (I_ADDR == ADDR_LISTEN_TIMING) begin
      rdata_next = {idle_tick_select_reg, receive_tick_select_reg,
                    wake_acceptance_rule_reg, post_accept_action_reg, 1'b0};
    end else if (I_ADDR == ADDR_LISTEN_IDLE) begin
      rdata_next = idle_phase_count_reg;
    end else if (I_ADDR == ADDR_LISTEN_RX) begin
      rdata_next = receive_phase_count_reg;
    end else if (I_ADDR == ADDR_REVISION) begin
      rdata_next = REVISION_CODE;
    end else if (I_ADDR == ADDR_AMP_LEVEL) begin
      rdata_next = {O_AMP_ZERO_EN, O_AMP_ONE_EN, O_AMP_TWO_EN, O_POWER_CODE};
    end else if (I_ADDR == ADDR_AMP_RAMP) begin
      rdata_next = {4'h0, O_RAMP_TIME_CODE};
    end else if (I_ADDR == ADDR_OVERCURRENT) begin
      rdata_next = {3'h0, O_OCP_EN, O_OCP_LIMIT_CODE};
    end else if (I_ADDR == ADDR_MODE) begin
      rdata_next = {3'h0, O_OP_MODE, 2'h0};
    end else if (I_ADDR == ADDR_OSC_CAL) begin
      rdata_next = {1'b0, !cal_busy_reg, 6'h01};
    end else if (I_ADDR == ADDR_LISTEN_CTRL) begin
      rdata_next = {7'h00, listen_en_reg};
    end else if (I_ADDR == ADDR_LISTEN_STATUS) begin
      rdata_next = {5'h00, accepted_reg, lstate_reg};
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      O_RDATA <= 8'h00;
    end else if (I_RD) begin
      O_RDATA <= rdata_next;
    end else begin
      O_RDATA <= 8'h00;
    end
  end
endmodule

// ---- verilog/ltc_pkg.sv ----
// package: register map, field codes, reset values and timing of the listen/tx config block
package ltc_pkg;
  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_MODE = 8'h01;
  localparam logic [7:0] ADDR_OSC_CAL = 8'h0a;
  localparam logic [7:0] ADDR_LISTEN_TIMING = 8'h0d;
  localparam logic [7:0] ADDR_LISTEN_IDLE = 8'h0e;
  localparam logic [7:0] ADDR_LISTEN_RX = 8'h0f;
  localparam logic [7:0] ADDR_REVISION = 8'h10;
  localparam logic [7:0] ADDR_AMP_LEVEL = 8'h11;
  localparam logic [7:0] ADDR_AMP_RAMP = 8'h12;
  localparam logic [7:0] ADDR_OVERCURRENT = 8'h13;
  localparam logic [7:0] ADDR_LISTEN_CTRL = 8'h40;
  localparam logic [7:0] ADDR_LISTEN_STATUS = 8'h41;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [1:0] RST_TICK_SEL = 2'h1;
  localparam logic [1:0] RST_POST_ACTION = 2'h1;
  localparam logic [7:0] RST_IDLE_COUNT = 8'hf5;
  localparam logic [7:0] RST_RX_COUNT = 8'h20;
  localparam logic [4:0] RST_POWER_CODE = 5'h1f;
  localparam logic [3:0] RST_RAMP_CODE = 4'h9;
  localparam logic [3:0] RST_OCP_CODE = 4'ha;
  // arbitrary neutral revision value
  localparam logic [7:0] REVISION_CODE = 8'h11;
  // ------------------------------------------------------------
  // codes
  // ------------------------------------------------------------
  localparam logic [1:0] TICK_64US = 2'h1;
  localparam logic [1:0] TICK_4MS = 2'h2;
  localparam logic [1:0] TICK_262MS = 2'h3;
  localparam logic [1:0] ACT_STAY_RX = 2'h0;
  localparam logic [1:0] ACT_GOTO_MODE = 2'h1;
  localparam logic [1:0] ACT_RESUME = 2'h2;
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_RX = 3'h4;
  localparam logic [2:0] MODE_MAX = 3'h4;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int BASE_TICK_US = 64;
  localparam int BASE_TICK_CYC = BASE_TICK_US * CLK_MHZ;
  // 4.1 ms and 262 ms are 64 and 4096 base ticks of 64 us
  localparam logic [11:0] MUL_64US = 12'h001;
  localparam logic [11:0] MUL_4MS = 12'h040;
  localparam logic [11:0] MUL_262MS = 12'hfff;
  localparam int CAL_CYCLES = 256;
  typedef enum logic [1:0] {
    LS_OFF = 2'b00,
    LS_IDLE = 2'b01,
    LS_RX = 2'b10,
    LS_HOLD = 2'b11
  } ltc_lstate_t;
endpackage
